// File: hw/pfta_defines.svh
/*
 * register offsets, field positions, reset values and timing counts
 * for the program flash table access unit.
 * assumes inclusion by bare name from files under hw/.
 */
`ifndef PFTA_DEFINES_SVH
`define PFTA_DEFINES_SVH

// register byte addresses on the apb bus
`define PFTA_OFS_CONTROL 12'h000
`define PFTA_OFS_UNLOCK 12'h004
`define PFTA_OFS_LATCH 12'h008
`define PFTA_OFS_PTR_UPPER 12'h00C
`define PFTA_OFS_PTR_HIGH 12'h010
`define PFTA_OFS_PTR_LOW 12'h014
`define PFTA_OFS_TABLE_OP 12'h018

// control register field positions
`define PFTA_BIT_SPACE 6
`define PFTA_BIT_ERASE 4
`define PFTA_BIT_ERROR 3
`define PFTA_BIT_WRITE_ENABLE 2
`define PFTA_BIT_START 1

// table operation command register fields
`define PFTA_BIT_OP_WRITE 2
`define PFTA_OP_MODE_LO 0

// unlock key bytes
`define PFTA_KEY_FIRST 8'h55
`define PFTA_KEY_SECOND 8'hAA

// holding register erased value
`define PFTA_HOLD_BLANK 8'hFF

// programming time, in microseconds, and its cycle count at 50 MHz
`define PFTA_PROG_TIME_US 2000
`define PFTA_CLK_MHZ 50
`define PFTA_PROG_CYCLES (`PFTA_PROG_TIME_US * `PFTA_CLK_MHZ)

`endif

// File: hw/pfta_pkg.sv
/*
 * types shared by the program flash table access unit.
 * assumes nothing of its surroundings.
 */
package pfta_pkg;

    // pointer action applied by a table operation
    typedef enum logic [1:0] {
        PFTA_PTR_KEEP = 2'b00,
        PFTA_PTR_POST_INC = 2'b01,
        PFTA_PTR_POST_DEC = 2'b10,
        PFTA_PTR_PRE_INC = 2'b11
    } pfta_ptr_act_t;

    // sequencer states
    typedef enum logic [2:0] {
        PFTA_ST_IDLE = 3'b000,
        PFTA_ST_READ = 3'b001,
        PFTA_ST_ERASE = 3'b010,
        PFTA_ST_PROG = 3'b011,
        PFTA_ST_WAIT = 3'b100
    } pfta_state_t;

    // unlock tracking
    typedef enum logic [1:0] {
        PFTA_UL_NONE = 2'b00,
        PFTA_UL_FIRST = 2'b01,
        PFTA_UL_OPEN = 2'b10
    } pfta_unlock_t;

endpackage : pfta_pkg

// File: hw/pfta_prog_timer.sv
/*
 * self-timed programming timer: counts a fixed number of cycles after start.
 * assumes start is a one-cycle pulse and is not raised while busy.
 */
`timescale 1ns/10ps
`include "pfta_defines.svh"
module pfta_prog_timer import pfta_pkg::*; #(
    parameter int unsigned CYCLES = `PFTA_PROG_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic start,
    output logic busy,
    output logic done
);
    // whole state of the timer
    typedef struct packed {
        logic [23:0] cnt;
        logic busy;
        logic done;
    } pfta_tmr_t;

    pfta_tmr_t s_q;
    pfta_tmr_t s_d;

    // next state: load on start, count down, pulse done at zero
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (start) begin
            s_d.busy = 1'b1;
            s_d.cnt = 24'(CYCLES - 1);
        end else if (s_q.busy) begin
            if (s_q.cnt == 24'h000000) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt - 24'h000001;
            end
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = s_q.busy;
    assign done = s_q.done;
endmodule : pfta_prog_timer

// File: hw/pfta_table_access.sv
/*
 * program flash table access unit: byte latch, 22-bit pointer, 16 holding
 * registers, row erase and block program sequencer behind an apb slave.
 * assumes a flash array port that answers a read in one cycle and accepts
 * one-cycle erase and program strobes; the timing of the array is covered
 * by the internal programming timer.
 */
`timescale 1ns/10ps
`include "pfta_defines.svh"
// Notes on behaviour
// - reads one byte; program 16, erase 64
// - no whole-array erase reachable
// - fetch stalls until timer ends operation
// - single 8-bit latch moves all bytes
// - read uses all 22 pointer bits
// - write stores latch into holding[ptr[3:0]]
// - program block chosen by ptr[21:4]
// - erase row chosen by ptr[21:6]
// - unlock register stores nothing, reads zero
// - control bit 6 selects configuration space
// - bit 4 makes start erase; cleared after
// - bit 2 enables writes; zero at reset
// - bit 3 flags interrupted or improper write
// - error leaves space select unchanged
// - bit 1 starts cycle; hardware clears it
// - control bits 7, 5, 0 read zero
// - 22-bit pointer from three bytes
// - auto update touches low 21 bits only
// - four pointer actions per table operation
// - start honoured only after 55h then AAh
// - holding registers reset to FFh after programming
// - stall about 2 ms per operation
module pfta_table_access import pfta_pkg::*; #(
    parameter int unsigned PROG_CYCLES = `PFTA_PROG_CYCLES
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // reset-cause input: high on the first cycle after a device reset
    input wire logic reset_seen,
    // flash array read port
    output logic [21:0] flash_addr,
    output logic flash_space,
    output logic flash_rd,
    input wire logic [7:0] flash_rdata,
    // flash array erase and program port
    output logic flash_erase,
    output logic flash_prog,
    output logic [127:0] flash_wdata,
    // core fetch stall
    output logic fetch_stall
);
    // whole state of the unit
    typedef struct packed {
        pfta_state_t st;
        pfta_unlock_t ul;
        logic [7:0] latch;
        logic [21:0] ptr;
        logic space;
        logic erase_en;
        logic err;
        logic write_enable;
        logic start;
        logic tmr_go;
        logic [15:0][7:0] hold;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [21:0] faddr;
        logic fspace;
        logic frd;
        logic ferase;
        logic fprog;
        logic stall;
        logic [1:0] rd_act;
    } pfta_state_s_t;

    pfta_state_s_t s_q;
    pfta_state_s_t s_d;
    logic tmr_busy;
    logic tmr_done;
    logic acc;
    logic [7:0] wb;
    logic [21:0] p_eff;

    // self-timed programming timer
    pfta_prog_timer #(
        .CYCLES(PROG_CYCLES)
    ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .start(s_q.tmr_go),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    // access phase, one answer per transfer, given after at least one wait cycle
    assign acc = psel && penable && !s_q.pready;
    assign wb = pwdata[7:0];

    // pointer after an auto update; top bit never moves
    function automatic logic [21:0] ptr_step(input logic [21:0] p, input logic up);
        logic [20:0] low;
        low = up ? p[20:0] + 21'h000001 : p[20:0] - 21'h000001;
        return {p[21], low};
    endfunction : ptr_step

    // next state
    always_comb begin
        s_d = s_q;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.frd = 1'b0;
        s_d.ferase = 1'b0;
        s_d.fprog = 1'b0;
        s_d.tmr_go = 1'b0;
        p_eff = s_q.ptr;
        // a reset seen in any state, whether or not a self-timed cycle ran, leaves the error flag
        if (reset_seen) begin
            s_d.err = 1'b1;
        end
        case (s_q.st)
            PFTA_ST_IDLE: begin
                if (acc) begin
                    s_d.pready = 1'b1;
                    s_d.prdata = 32'h00000000;
                    if (pwrite) begin
                        // any write other than the second key drops an open unlock
                        if (paddr != `PFTA_OFS_CONTROL) begin
                            s_d.ul = PFTA_UL_NONE;
                        end
                        if (paddr == `PFTA_OFS_CONTROL) begin
                            s_d.space = wb[`PFTA_BIT_SPACE];
                            s_d.erase_en = wb[`PFTA_BIT_ERASE];
                            s_d.write_enable = wb[`PFTA_BIT_WRITE_ENABLE];
                            s_d.err = wb[`PFTA_BIT_ERROR] | reset_seen;
                            s_d.ul = PFTA_UL_NONE;
                            if (wb[`PFTA_BIT_START]) begin
                                if (wb[`PFTA_BIT_WRITE_ENABLE] && s_q.ul == PFTA_UL_OPEN) begin
                                    // honoured start: stall and launch
                                    s_d.start = 1'b1;
                                    s_d.err = reset_seen; // a fresh run starts clean
                                    s_d.stall = 1'b1;
                                    s_d.tmr_go = 1'b1;
                                    s_d.fspace = wb[`PFTA_BIT_SPACE];
                                    if (wb[`PFTA_BIT_ERASE]) begin
                                        // row only, low six bits dropped
                                        s_d.faddr = {s_q.ptr[21:6], 6'h00};
                                        s_d.ferase = 1'b1;
                                        s_d.st = PFTA_ST_ERASE;
                                    end else begin
                                        // 16-byte block from the holding registers
                                        s_d.faddr = {s_q.ptr[21:4], 4'h0};
                                        s_d.fprog = 1'b1;
                                        s_d.st = PFTA_ST_PROG;
                                    end
                                end else begin
                                    // improper start is ignored and flagged
                                    s_d.err = 1'b1; // space select kept
                                end
                            end
                        end else if (paddr == `PFTA_OFS_UNLOCK) begin
                            // unlock keys tracked, nothing stored
                            if (wb == `PFTA_KEY_FIRST) begin
                                s_d.ul = PFTA_UL_FIRST;
                            end else if (wb == `PFTA_KEY_SECOND && s_q.ul == PFTA_UL_FIRST) begin
                                s_d.ul = PFTA_UL_OPEN;
                            end
                        end else if (paddr == `PFTA_OFS_LATCH) begin
                            s_d.latch = wb;
                        end else if (paddr == `PFTA_OFS_PTR_UPPER) begin
                            s_d.ptr[21:16] = wb[5:0];
                        end else if (paddr == `PFTA_OFS_PTR_HIGH) begin
                            s_d.ptr[15:8] = wb;
                        end else if (paddr == `PFTA_OFS_PTR_LOW) begin
                            s_d.ptr[7:0] = wb;
                        end else if (paddr == `PFTA_OFS_TABLE_OP) begin
                            // table operation: pre-increment first if asked
                            if (pfta_ptr_act_t'(wb[1:0]) == PFTA_PTR_PRE_INC) begin
                                p_eff = ptr_step(s_q.ptr, 1'b1);
                            end
                            if (wb[`PFTA_BIT_OP_WRITE]) begin
                                s_d.hold[p_eff[3:0]] = s_q.latch;
                            end else begin
                                // read whole 22-bit byte address into latch
                                s_d.faddr = p_eff;
                                s_d.fspace = s_q.space;
                                s_d.frd = 1'b1;
                                s_d.st = PFTA_ST_READ;
                                s_d.pready = 1'b0;
                            end
                            s_d.rd_act = wb[1:0];
                            case (pfta_ptr_act_t'(wb[1:0]))
                                PFTA_PTR_POST_INC: s_d.ptr = ptr_step(s_q.ptr, 1'b1);
                                PFTA_PTR_POST_DEC: s_d.ptr = ptr_step(s_q.ptr, 1'b0);
                                PFTA_PTR_PRE_INC: s_d.ptr = p_eff;
                                default: s_d.ptr = s_q.ptr;
                            endcase
                        end else begin
                            s_d.pslverr = 1'b1; // unmapped address
                        end
                    end else begin
                        // register reads
                        if (paddr == `PFTA_OFS_CONTROL) begin
                            s_d.prdata[`PFTA_BIT_SPACE] = s_q.space; // reserved bits stay zero
                            s_d.prdata[`PFTA_BIT_ERASE] = s_q.erase_en;
                            s_d.prdata[`PFTA_BIT_ERROR] = s_q.err;
                            s_d.prdata[`PFTA_BIT_WRITE_ENABLE] = s_q.write_enable;
                            s_d.prdata[`PFTA_BIT_START] = s_q.start;
                        end else if (paddr == `PFTA_OFS_UNLOCK) begin
                            s_d.prdata = 32'h00000000;
                        end else if (paddr == `PFTA_OFS_LATCH) begin
                            s_d.prdata[7:0] = s_q.latch;
                        end else if (paddr == `PFTA_OFS_PTR_UPPER) begin
                            s_d.prdata[5:0] = s_q.ptr[21:16];
                        end else if (paddr == `PFTA_OFS_PTR_HIGH) begin
                            s_d.prdata[7:0] = s_q.ptr[15:8];
                        end else if (paddr == `PFTA_OFS_PTR_LOW) begin
                            s_d.prdata[7:0] = s_q.ptr[7:0];
                        end else if (paddr == `PFTA_OFS_TABLE_OP) begin
                            s_d.prdata = 32'h00000000;
                        end else begin
                            s_d.pslverr = 1'b1;
                        end
                    end
                end
            end
            PFTA_ST_READ: begin
                // array answers one cycle after the strobe
                s_d.st = PFTA_ST_WAIT;
            end
            PFTA_ST_WAIT: begin
                s_d.latch = flash_rdata;
                s_d.pready = 1'b1;
                s_d.prdata = 32'h00000000;
                s_d.st = PFTA_ST_IDLE;
            end
            PFTA_ST_ERASE, PFTA_ST_PROG: begin
                // bus held off while fetch is stalled; timer ends it
                if (tmr_done) begin
                    s_d.start = 1'b0;
                    s_d.stall = 1'b0;
                    s_d.err = s_q.err | reset_seen; // clear unless a reset hit the run
                    if (s_q.st == PFTA_ST_ERASE) begin
                        s_d.erase_en = 1'b0;
                    end else begin
                        for (int i = 0; i < 16; i++) begin
                            s_d.hold[i] = `PFTA_HOLD_BLANK;
                        end
                    end
                    s_d.st = PFTA_ST_IDLE;
                end
            end
            default: begin
                s_d.st = PFTA_ST_IDLE;
            end
        endcase
    end

    // state register; holding registers reset blank
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.hold <= {16{`PFTA_HOLD_BLANK}};
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flip-flops
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign flash_addr = s_q.faddr;
    assign flash_space = s_q.fspace;
    assign flash_rd = s_q.frd;
    assign flash_erase = s_q.ferase;
    assign flash_prog = s_q.fprog;
    assign flash_wdata = s_q.hold; // bytes FFh leave flash unchanged
    assign fetch_stall = s_q.stall;
endmodule : pfta_table_access

// File: dv/pfta_table_access_chk.sv
/* timing relations on the ports of the flash table access unit.
   assumes a bind onto pfta_table_access with the same PROG_CYCLES. */
`timescale 1ns/10ps
`include "pfta_defines.svh"
module pfta_table_access_chk import pfta_pkg::*; #(
    parameter int unsigned PROG_CYCLES = 8
) (
    // apb side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // flash side
    input wire logic [21:0] flash_addr,
    input wire logic flash_rd,
    input wire logic flash_erase,
    input wire logic flash_prog,
    input wire logic [127:0] flash_wdata,
    input wire logic fetch_stall
);
    logic [31:0] stall_q; // length of the current stall
    // count stalled cycles, clear when fetching again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stall_q <= 32'h0;
        end else begin
            stall_q <= fetch_stall ? stall_q + 32'h1 : 32'h0;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_PROG_STALL: assert property (flash_prog |-> fetch_stall)
        else $error("program strobe without fetch stall");
    AST_ERASE_ROW: assert property (flash_erase |-> fetch_stall && flash_addr[5:0] == 6'h00)
        else $error("erase address not row aligned");
    AST_PROG_BLOCK: assert property (flash_prog |-> flash_addr[3:0] == 4'h0)
        else $error("program address not block aligned");
    AST_ONE_KIND: assert property (!(flash_prog && flash_erase))
        else $error("erase and program together");
    AST_STALL_LEN: assert property ($fell(fetch_stall) |-> stall_q >= PROG_CYCLES && stall_q <= PROG_CYCLES + 4)
        else $error("stall length off");
    AST_STALL_MAX: assert property (fetch_stall |-> stall_q <= PROG_CYCLES + 4)
        else $error("stall too long");
    AST_BLANK_AFTER: assert property ($fell(fetch_stall) |-> ##[0:2] flash_wdata == {16{8'hFF}})
        else $error("holding registers not blank after operation");
    AST_UNLOCK_ZERO: assert property (pready && !pwrite && paddr == `PFTA_OFS_UNLOCK |-> prdata == 32'h0)
        else $error("unlock register read not zero");
    AST_CTRL_RSVD: assert property (pready && !pwrite && paddr == `PFTA_OFS_CONTROL
        |-> prdata[31:8] == 24'h0 && !prdata[7] && !prdata[5] && !prdata[0])
        else $error("control reserved bits not zero");
    AST_RD_PULSE: assert property (flash_rd |=> !flash_rd)
        else $error("flash read strobe longer than one cycle");
    // main scenarios reached
    cover property (flash_prog);
    cover property (flash_erase);
    cover property (pslverr);
    cover property ($fell(fetch_stall));
endmodule : pfta_table_access_chk

bind pfta_table_access pfta_table_access_chk #(.PROG_CYCLES(PROG_CYCLES)) pfta_table_access_chk_i (
    .pclk(pclk), .presetn(presetn), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr), .flash_rd(flash_rd),
    .flash_erase(flash_erase), .flash_prog(flash_prog), .flash_wdata(flash_wdata),
    .fetch_stall(fetch_stall)
);

// File: dv/pfta_flash_model.sv
/* behavioural flash array read port: one byte per read, pattern of the address.
   assumes the unit samples read data two cycles after its read strobe. */
`timescale 1ns/10ps
module pfta_flash_model (
    // clock
    input wire logic pclk,
    // array read port
    input wire logic [21:0] flash_addr,
    input wire logic flash_space,
    input wire logic flash_rd,
    output logic [7:0] flash_rdata
);
    logic [1:0] hold_q; // cycles the read byte still stands
    initial begin
        flash_rdata = 8'h00;
        hold_q = 2'h0;
    end
    // answer a strobe, then scramble the bus once the data has expired
    always @(posedge pclk) begin
        if (flash_rd) begin
            flash_rdata <= flash_addr[7:0] ^ flash_addr[15:8] ^ {2'h0, flash_addr[21:16]} ^ {flash_space, 7'h00};
            hold_q <= 2'h2;
        end else if (hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
        end else begin
            flash_rdata <= ~flash_rdata;
        end
    end
endmodule : pfta_flash_model

// File: dv/pfta_table_access_tb.sv
/* self-checking bench for the flash table access unit over apb.
   assumes the unit, the array model and the checker are compiled alongside. */
`timescale 1ns/10ps
`include "pfta_defines.svh"
module pfta_table_access_tb;
    localparam int unsigned PROG_CYCLES = 8; // short timer for simulation
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, reset_seen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [21:0] flash_addr, op_addr;
    logic flash_space, flash_rd, flash_erase, flash_prog, op_space, slv_err, fetch_stall;
    logic [7:0] flash_rdata;
    logic [127:0] flash_wdata, op_data;
    int fails, samples_checked, n_prog, n_erase, cyc;
    pfta_table_access #(.PROG_CYCLES(PROG_CYCLES)) pfta_table_access_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reset_seen(reset_seen), .flash_addr(flash_addr), .flash_space(flash_space),
        .flash_rd(flash_rd), .flash_rdata(flash_rdata), .flash_erase(flash_erase),
        .flash_prog(flash_prog), .flash_wdata(flash_wdata), .fetch_stall(fetch_stall)
    );
    pfta_flash_model pfta_flash_model_i (
        .pclk(pclk), .flash_addr(flash_addr), .flash_space(flash_space),
        .flash_rd(flash_rd), .flash_rdata(flash_rdata)
    );
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // record every erase and program strobe for later comparison
    always @(posedge pclk) begin
        if (flash_prog) begin
            n_prog++;
            op_addr = flash_addr;
            op_data = flash_wdata;
        end
        if (flash_erase) begin
            n_erase++;
            op_addr = flash_addr;
            op_space = flash_space;
        end
        cyc++;
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one apb transfer, waiting for pready under a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 1000);
        if (n >= 1000) fails++;
        q = prdata[7:0];
        slv_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic set_ptr(input logic [21:0] p);
        logic [7:0] q;
        apb(1'b1, `PFTA_OFS_PTR_UPPER, {2'h0, p[21:16]}, q);
        apb(1'b1, `PFTA_OFS_PTR_HIGH, p[15:8], q);
        apb(1'b1, `PFTA_OFS_PTR_LOW, p[7:0], q);
    endtask : set_ptr
    // enable, unlock, then start with the given control value
    task automatic kick(input logic [7:0] c);
        logic [7:0] q;
        apb(1'b1, `PFTA_OFS_CONTROL, c, q);
        apb(1'b1, `PFTA_OFS_UNLOCK, `PFTA_KEY_FIRST, q);
        apb(1'b1, `PFTA_OFS_UNLOCK, `PFTA_KEY_SECOND, q);
        apb(1'b1, `PFTA_OFS_CONTROL, c | 8'h02, q);
    endtask : kick
    function automatic logic [7:0] fbyte(input logic [21:0] a);
        return a[7:0] ^ a[15:8] ^ {2'h0, a[21:16]};
    endfunction : fbyte
    task automatic t_regs();
        logic [7:0] q;
        apb(1'b0, `PFTA_OFS_CONTROL, 8'h00, q);
        chk("enable at reset", 1'b0, q[2]);
        apb(1'b1, `PFTA_OFS_UNLOCK, 8'h55, q);
        apb(1'b0, `PFTA_OFS_UNLOCK, 8'h00, q);
        chk("unlock read", 8'h00, q);
        apb(1'b1, `PFTA_OFS_CONTROL, 8'hA1, q);
        apb(1'b0, `PFTA_OFS_CONTROL, 8'h00, q);
        chk("control unused bits", 8'h00, q);
        apb(1'b0, 12'h01C, 8'h00, q);
        chk("unmapped slave error", 1'b1, slv_err);
    endtask : t_regs
    task automatic t_read();
        logic [21:0] np, ra;
        logic [20:0] lo;
        logic [7:0] q;
        for (int a = 0; a < 4; a++) begin
            set_ptr(22'h3FFFFF);
            lo = 21'h1FFFFF;
            if (a == 1 || a == 3) lo = lo + 21'h1;
            if (a == 2) lo = lo - 21'h1;
            np = {1'b1, lo};
            ra = (a == 3) ? np : 22'h3FFFFF;
            apb(1'b1, `PFTA_OFS_TABLE_OP, 8'(a), q);
            apb(1'b0, `PFTA_OFS_LATCH, 8'h00, q);
            chk("latch after read", fbyte(ra), q);
            apb(1'b0, `PFTA_OFS_PTR_UPPER, 8'h00, q);
            chk("pointer upper", {2'h0, np[21:16]}, q);
            apb(1'b0, `PFTA_OFS_PTR_LOW, 8'h00, q);
            chk("pointer low", np[7:0], q);
        end
    endtask : t_read
    task automatic t_prog();
        logic [127:0] hold;
        logic [7:0] q;
        int np;
        hold = {16{8'hFF}};
        set_ptr(22'h001230);
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, `PFTA_OFS_LATCH, 8'h10 + 8'(i), q);
            apb(1'b1, `PFTA_OFS_TABLE_OP, 8'h05, q);
            hold[8*i +: 8] = 8'h10 + 8'(i);
        end
        chk("holding bytes", hold, flash_wdata);
        set_ptr(22'h001230);
        np = n_prog;
        kick(8'h04);
        chk("stall during program", 1'b1, fetch_stall);
        apb(1'b0, `PFTA_OFS_CONTROL, 8'h00, q);
        chk("control after program", 8'h04, q);
        chk("program count", 1, n_prog - np);
        chk("program block", 22'h001230, op_addr);
        chk("programmed data", hold, op_data);
        chk("holding blank", {16{8'hFF}}, flash_wdata);
    endtask : t_prog
    task automatic t_erase();
        logic [7:0] q;
        int np, ne;
        np = n_prog;
        ne = n_erase;
        set_ptr(22'h01ABCD);
        kick(8'h54);
        apb(1'b0, `PFTA_OFS_CONTROL, 8'h00, q);
        chk("control after erase", 8'h44, q);
        chk("erase count", 1, n_erase - ne);
        chk("no program on erase", np, n_prog);
        chk("erase row", 22'h01ABC0, op_addr);
        chk("erase space", 1'b1, op_space);
    endtask : t_erase
    task automatic t_bad();
        logic [7:0] q;
        int nt;
        nt = n_prog + n_erase;
        apb(1'b1, `PFTA_OFS_CONTROL, 8'h46, q);
        apb(1'b0, `PFTA_OFS_CONTROL, 8'h00, q);
        chk("start without unlock", 8'h4C, q);
        apb(1'b1, `PFTA_OFS_CONTROL, 8'h00, q);
        apb(1'b1, `PFTA_OFS_UNLOCK, `PFTA_KEY_FIRST, q);
        apb(1'b1, `PFTA_OFS_UNLOCK, `PFTA_KEY_SECOND, q);
        apb(1'b1, `PFTA_OFS_CONTROL, 8'h02, q);
        apb(1'b0, `PFTA_OFS_CONTROL, 8'h00, q);
        chk("start without enable", 8'h08, q);
        chk("no operation on refusal", nt, n_prog + n_erase);
    endtask : t_bad
    task automatic t_abort();
        logic [7:0] q;
        kick(8'h04);
        @(posedge pclk);
        reset_seen <= 1'b1;
        @(posedge pclk);
        reset_seen <= 1'b0;
        apb(1'b0, `PFTA_OFS_CONTROL, 8'h00, q);
        chk("error after interrupted write", 1'b1, q[3]);
    endtask : t_abort
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        reset_seen = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_read();
        t_prog();
        t_erase();
        t_bad();
        t_abort();
        give_verdict();
    end
endmodule : pfta_table_access_tb
